// ### jtdp_debug_port.sv
// test access port with boundary scan, bypass and debug access path
`timescale 1ns/1ps
`default_nettype none
`include "jtdp_regs.svh"
module jtdp_debug_port #(
    parameter int BSR_LEN = 16
) (
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    output logic                    tdo,
    output logic                    tdo_oe,
    input  wire logic [BSR_LEN-1:0] bsr_in,
    output logic      [BSR_LEN-1:0] bsr_out,
    output logic                    bsr_drive,
    output logic                    dbg_req,
    output logic                    dbg_we,
    output logic      [1:0]         dbg_size,
    output logic      [31:0]        dbg_addr,
    output logic      [31:0]        dbg_wdata,
    input  wire logic               dbg_ack,
    input  wire logic               dbg_err,
    input  wire logic [31:0]        dbg_rdata
);
    localparam int DL = `JTDP_DBG_LEN;
    localparam int IL = `JTDP_IR_LEN;

    // pin synchronisers; the last stage of tck feeds the edge finder
    logic [2:0]         tck_q;
    logic [1:0]         tms_q;
    logic [1:0]         tdi_q;
    logic [BSR_LEN-1:0] bsr_q1;
    logic [BSR_LEN-1:0] bsr_q2;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tck_q  <= 3'h7; // probe parks the clock high: no false edge
            tms_q  <= 2'h3;
            tdi_q  <= 2'h0;
            bsr_q1 <= '0;
            bsr_q2 <= '0;
        end else begin
            tck_q  <= {tck_q[1:0], tck};
            tms_q  <= {tms_q[0], tms};
            tdi_q  <= {tdi_q[0], tdi};
            bsr_q1 <= bsr_in;
            bsr_q2 <= bsr_q1;
        end
    end

    wire tck_rise = tck_q[1] && !tck_q[2];
    wire tck_fall = !tck_q[1] && tck_q[2];
    wire tms_s    = tms_q[1];
    wire tdi_s    = tdi_q[1];

    jtdp_pkg::jtdp_state_t state;

    jtdp_tap_fsm u_fsm (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .tck_rise (tck_rise),
        .tms      (tms_s),
        .state    (state)
    );

    logic [IL-1:0]      ir;
    logic [IL-1:0]      ir_sh;
    logic               bypass;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [DL-1:0]      dbg_sh;
    logic [31:0]        base;
    logic [31:0]        last_rdata;
    logic               err_flag;

    wire st_cap_dr = state == jtdp_pkg::TAP_CAP_DR;
    wire st_sh_dr  = state == jtdp_pkg::TAP_SH_DR;
    wire st_up_dr  = state == jtdp_pkg::TAP_UP_DR;
    wire st_sh_ir  = state == jtdp_pkg::TAP_SH_IR;
    wire st_reset  = state == jtdp_pkg::TAP_RESET;

    // decode; unknown codes fall back to bypass as the standard asks
    wire sel_bsr = ir == `JTDP_IR_EXTEST || ir == `JTDP_IR_SAMPLE;
    wire sel_dbg = ir == `JTDP_IR_DEBUG;
    wire sel_byp = !sel_bsr && !sel_dbg;

    wire path_bit = st_sh_ir ? ir_sh[0]
                  : sel_bsr  ? bsr_sh[0]
                  : sel_dbg  ? dbg_sh[0]
                  : bypass;
    wire in_shift = st_sh_dr || st_sh_ir;

    // debug command fields as shifted in
    wire [1:0]  cmd_size = dbg_sh[`JTDP_SIZE_LSB +: 2];
    wire        cmd_we   = dbg_sh[`JTDP_WE_BIT];
    wire        cmd_ofs  = dbg_sh[`JTDP_OFS_BIT];
    wire [31:0] cmd_addr = dbg_sh[`JTDP_ADDR_LSB +: 32];
    wire [31:0] cmd_data = dbg_sh[`JTDP_DATA_LSB +: 32];
    wire [31:0] eff_addr = cmd_ofs ? base + cmd_addr : cmd_addr;
    wire        issue    = tck_rise && st_up_dr && sel_dbg && !dbg_req;
    wire        bad_size = cmd_size == `JTDP_SIZE_BAD;

    wire [DL-1:0] dbg_status = {last_rdata, 34'h0, dbg_req, err_flag};

    // instruction register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ir    <= `JTDP_IR_BYPASS;
            ir_sh <= '0;
        end else if (tck_rise) begin
            if (st_reset)
                ir <= `JTDP_IR_BYPASS;
            else if (state == jtdp_pkg::TAP_UP_IR)
                ir <= ir_sh;
            if (state == jtdp_pkg::TAP_CAP_IR)
                ir_sh <= `JTDP_IR_CAPTURE;
            else if (st_sh_ir)
                ir_sh <= {tdi_s, ir_sh[IL-1:1]};
        end
    end

    // data registers shift on the rising edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bypass <= 1'b0;
            bsr_sh <= '0;
            dbg_sh <= '0;
        end else if (tck_rise) begin
            if (st_cap_dr) begin
                bypass <= 1'b0;
                bsr_sh <= bsr_q2;
                dbg_sh <= dbg_status;
            end else if (st_sh_dr) begin
                if (sel_byp)
                    bypass <= tdi_s;
                if (sel_bsr)
                    bsr_sh <= {tdi_s, bsr_sh[BSR_LEN-1:1]};
                if (sel_dbg)
                    dbg_sh <= {tdi_s, dbg_sh[DL-1:1]};
            end
        end
    end

    // update latch preloads under either boundary code; pins driven
    // only under extest
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bsr_out   <= '0;
            bsr_drive <= 1'b0;
        end else begin
            bsr_drive <= ir == `JTDP_IR_EXTEST && !st_reset;
            if (tck_rise && st_up_dr && sel_bsr)
                bsr_out <= bsr_sh;
        end
    end

    // test output moves on the falling edge only
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo    <= in_shift ? path_bit : 1'b0;
            tdo_oe <= in_shift;
        end
    end

    // request stays up until acknowledged; no halt gating on purpose
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dbg_req    <= 1'b0;
            dbg_we     <= 1'b0;
            dbg_size   <= 2'h0;
            dbg_addr   <= 32'h0;
            dbg_wdata  <= 32'h0;
            base       <= 32'h0;
            last_rdata <= 32'h0;
            err_flag   <= 1'b0;
        end else if (dbg_req) begin
            if (dbg_ack) begin
                dbg_req    <= 1'b0;
                err_flag   <= dbg_err;
                last_rdata <= dbg_rdata;
            end
        end else if (issue) begin
            // a bad size is refused locally; the session carries on
            err_flag  <= bad_size;
            dbg_req   <= !bad_size;
            dbg_we    <= cmd_we;
            dbg_size  <= cmd_size;
            dbg_addr  <= eff_addr;
            dbg_wdata <= cmd_data;
            if (!cmd_ofs)
                base <= cmd_addr;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_tdo_on_fall: assert property (
        !tck_fall |=> $stable(tdo) && $stable(tdo_oe))
        else $error("test output moved away from a falling edge");

    a_tdo_enable: assert property (
        tck_fall |=> tdo_oe == $past(in_shift))
        else $error("test output enable outside the shift states");

    a_tdi_sampled: assert property (
        tck_rise && st_sh_dr && sel_byp |=> bypass == $past(tdi_s))
        else $error("test input not taken on the rising edge");

    a_bypass_zero: assert property (
        tck_rise && st_cap_dr |=> bypass == 1'b0)
        else $error("bypass bit did not capture zero");

    sequence s_byp_shift;
        tck_fall && st_sh_dr && sel_byp;
    endsequence

    a_path_select: assert property (
        s_byp_shift ##1 1'b1 |-> tdo == $past(bypass))
        else $error("bypass path not presented at the test output");

    sequence s_err_answer;
        dbg_req && dbg_ack && dbg_err;
    endsequence

    a_err_session: assert property (
        s_err_answer |=> err_flag && !dbg_req)
        else $error("access error not flagged or port left busy");

    a_req_held: assert property (
        dbg_req && !dbg_ack |=> dbg_req && $stable(dbg_addr))
        else $error("debug request dropped before its answer");

    a_size_legal: assert property (
        $rose(dbg_req) |-> dbg_size != `JTDP_SIZE_BAD
                           && dbg_addr == $past(eff_addr))
        else $error("debug request with bad size or address");
endmodule
`default_nettype wire

// ### jtdp_regs.svh
// constants of the test access and debug port
// Notes on behaviour
// - The serial test output changes only on a falling edge of the test clock.
// - The test output is driven only in Shift-DR or Shift-IR, else released.
// - The serial test input is taken on each rising edge of the test clock.
// - Mode-select low in Test-Logic-Reset moves the controller to Run-Test/Idle.
// - All instructions and serial data are timed by the probe's test clock.
// - Instruction, boundary-scan and bypass registers form selectable paths.
// - A debug access to a bad address is flagged and the port stays usable.
// - Debug accesses come in byte, word and long size, full or offset address.
// - Debug register accesses still complete while the processor is halted.
`ifndef JTDP_REGS_SVH
`define JTDP_REGS_SVH

`define JTDP_IR_LEN       4
`define JTDP_IR_EXTEST    4'h0
`define JTDP_IR_SAMPLE    4'h1
`define JTDP_IR_DEBUG     4'h8
`define JTDP_IR_BYPASS    4'hF
`define JTDP_IR_CAPTURE   4'h1

`define JTDP_DBG_LEN      68
`define JTDP_SIZE_LSB     0
`define JTDP_WE_BIT       2
`define JTDP_OFS_BIT      3
`define JTDP_ADDR_LSB     4
`define JTDP_DATA_LSB     36
`define JTDP_ST_ERR       0
`define JTDP_ST_BUSY      1
`define JTDP_SIZE_BAD     2'h3

`define JTDP_TLR_COUNT    3'h5

`endif

// ### jtdp_pkg.sv
// types of the test access and debug port
`default_nettype none
package jtdp_pkg;
    typedef enum logic [15:0] {
        TAP_RESET   = 16'h0001,
        TAP_IDLE    = 16'h0002,
        TAP_SEL_DR  = 16'h0004,
        TAP_CAP_DR  = 16'h0008,
        TAP_SH_DR   = 16'h0010,
        TAP_EX1_DR  = 16'h0020,
        TAP_PA_DR   = 16'h0040,
        TAP_EX2_DR  = 16'h0080,
        TAP_UP_DR   = 16'h0100,
        TAP_SEL_IR  = 16'h0200,
        TAP_CAP_IR  = 16'h0400,
        TAP_SH_IR   = 16'h0800,
        TAP_EX1_IR  = 16'h1000,
        TAP_PA_IR   = 16'h2000,
        TAP_EX2_IR  = 16'h4000,
        TAP_UP_IR   = 16'h8000
    } jtdp_state_t;
endpackage
`default_nettype wire

// ### jtdp_tap_fsm.sv
// test access port controller state machine
`timescale 1ns/1ps
`default_nettype none
`include "jtdp_regs.svh"
module jtdp_tap_fsm (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 tck_rise,
    input  wire logic                 tms,
    output var  jtdp_pkg::jtdp_state_t state
);
    jtdp_pkg::jtdp_state_t next_state;
    logic [2:0]            tms_run;

    always_comb begin
        next_state = state;
        unique case (state)
            jtdp_pkg::TAP_RESET:  next_state = tms ? jtdp_pkg::TAP_RESET
                                                   : jtdp_pkg::TAP_IDLE;
            jtdp_pkg::TAP_IDLE:   next_state = tms ? jtdp_pkg::TAP_SEL_DR
                                                   : jtdp_pkg::TAP_IDLE;
            jtdp_pkg::TAP_SEL_DR: next_state = tms ? jtdp_pkg::TAP_SEL_IR
                                                   : jtdp_pkg::TAP_CAP_DR;
            jtdp_pkg::TAP_CAP_DR: next_state = tms ? jtdp_pkg::TAP_EX1_DR
                                                   : jtdp_pkg::TAP_SH_DR;
            jtdp_pkg::TAP_SH_DR:  next_state = tms ? jtdp_pkg::TAP_EX1_DR
                                                   : jtdp_pkg::TAP_SH_DR;
            jtdp_pkg::TAP_EX1_DR: next_state = tms ? jtdp_pkg::TAP_UP_DR
                                                   : jtdp_pkg::TAP_PA_DR;
            jtdp_pkg::TAP_PA_DR:  next_state = tms ? jtdp_pkg::TAP_EX2_DR
                                                   : jtdp_pkg::TAP_PA_DR;
            jtdp_pkg::TAP_EX2_DR: next_state = tms ? jtdp_pkg::TAP_UP_DR
                                                   : jtdp_pkg::TAP_SH_DR;
            jtdp_pkg::TAP_UP_DR:  next_state = tms ? jtdp_pkg::TAP_SEL_DR
                                                   : jtdp_pkg::TAP_IDLE;
            jtdp_pkg::TAP_SEL_IR: next_state = tms ? jtdp_pkg::TAP_RESET
                                                   : jtdp_pkg::TAP_CAP_IR;
            jtdp_pkg::TAP_CAP_IR: next_state = tms ? jtdp_pkg::TAP_EX1_IR
                                                   : jtdp_pkg::TAP_SH_IR;
            jtdp_pkg::TAP_SH_IR:  next_state = tms ? jtdp_pkg::TAP_EX1_IR
                                                   : jtdp_pkg::TAP_SH_IR;
            jtdp_pkg::TAP_EX1_IR: next_state = tms ? jtdp_pkg::TAP_UP_IR
                                                   : jtdp_pkg::TAP_PA_IR;
            jtdp_pkg::TAP_PA_IR:  next_state = tms ? jtdp_pkg::TAP_EX2_IR
                                                   : jtdp_pkg::TAP_PA_IR;
            jtdp_pkg::TAP_EX2_IR: next_state = tms ? jtdp_pkg::TAP_UP_IR
                                                   : jtdp_pkg::TAP_SH_IR;
            jtdp_pkg::TAP_UP_IR:  next_state = tms ? jtdp_pkg::TAP_SEL_DR
                                                   : jtdp_pkg::TAP_IDLE;
            default:              next_state = jtdp_pkg::TAP_RESET;
        endcase
    end

    // state only moves on a test-clock rising edge
    always_ff @(posedge ref_clk) begin
        if (reset)
            state <= jtdp_pkg::TAP_RESET;
        else if (tck_rise)
            state <= next_state;
    end

    // helper: consecutive mode-select-high clock count, saturating
    always_ff @(posedge ref_clk) begin
        if (reset)
            tms_run <= 3'h0;
        else if (tck_rise)
            tms_run <= !tms ? 3'h0
                     : (tms_run == `JTDP_TLR_COUNT) ? tms_run
                     : tms_run + 3'h1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_tms_five_reset: assert property (
        tms_run == `JTDP_TLR_COUNT |-> state == jtdp_pkg::TAP_RESET)
        else $error("five high mode-select clocks did not reach reset");

    a_reset_to_idle: assert property (
        tck_rise && !tms && state == jtdp_pkg::TAP_RESET
        |=> state == jtdp_pkg::TAP_IDLE)
        else $error("reset state did not move to idle");
endmodule
`default_nettype wire

// ### jtdp_probe.sv
// test probe model: drives test clock, mode select and data in
`timescale 1ns/1ps
`default_nettype none
module jtdp_probe (
    input  wire logic ref_clk,
    input  wire logic tdo,
    input  wire logic tdo_oe,
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi
);
    int   bad;
    logic last_tdo;

    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b1;
        bad = 0;
        last_tdo = 1'b0;
    end

    // one 400 ns period, entered on a ref_clk edge: low 4, high 4 cycles
    // the clock stands high between calls, as a real probe may stop it
    task automatic step(input logic m, input logic d, input logic oe);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (2) @(posedge ref_clk);
        // a change here would mean tdo moved ahead of the falling edge
        if (tdo !== last_tdo)
            bad++;
        repeat (2) @(posedge ref_clk);
        tck <= 1'b1;
        repeat (4) @(posedge ref_clk);
        if (tdo_oe !== oe)
            bad++;
        last_tdo = tdo;
    endtask

    // only from a state where tdo is released
    task automatic to_idle();
        repeat (5) step(1'b1, ~tdi, 1'b0);
        step(1'b0, ~tdi, 1'b0);
    endtask

    // idle to shift, n bits lsb first, then update and back to idle
    task automatic scan(input logic ir, input int n, input logic [67:0] din,
                        output logic [67:0] dout);
        dout = '0;
        step(1'b1, ~tdi, 1'b0);
        if (ir)
            step(1'b1, ~tdi, 1'b0);
        step(1'b0, ~tdi, 1'b0);
        step(1'b0, ~tdi, 1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], 1'b1);
            dout[i] = last_tdo;
        end
        step(1'b1, ~tdi, 1'b0);
        step(1'b0, ~tdi, 1'b0);
    endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the test access and debug port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int BSR = 16;
    logic           ref_clk;
    logic           reset;
    wire            tck;
    wire            tms;
    wire            tdi;
    logic           tdo;
    logic           tdo_oe;
    logic [BSR-1:0] bsr_in;
    logic [BSR-1:0] bsr_out;
    logic           bsr_drive;
    logic           dbg_req;
    logic           dbg_we;
    logic [1:0]     dbg_size;
    logic [31:0]    dbg_addr;
    logic [31:0]    dbg_wdata;
    logic           dbg_ack;
    logic           dbg_err;
    logic [31:0]    dbg_rdata;
    logic [67:0]    dout;
    int             error_cnt;
    int             n_checks;

    jtdp_debug_port #(.BSR_LEN(BSR)) uut (
        .ref_clk(ref_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .bsr_in(bsr_in), .bsr_out(bsr_out),
        .bsr_drive(bsr_drive), .dbg_req(dbg_req), .dbg_we(dbg_we),
        .dbg_size(dbg_size), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
        .dbg_ack(dbg_ack), .dbg_err(dbg_err), .dbg_rdata(dbg_rdata)
    );
    jtdp_probe p (
        .ref_clk(ref_clk), .tdo(tdo), .tdo_oe(tdo_oe),
        .tck(tck), .tms(tms), .tdi(tdi)
    );

    task automatic chk(input logic [67:0] got, input logic [67:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic t_bypass();
        p.to_idle();
        p.scan(1'b0, 8, 68'hA5, dout);
        chk(dout[7:0], 8'h4A);
        p.scan(1'b1, 4, 68'hF, dout);
        chk(dout[3:0], 4'h1);
        // an undefined code must fall back to the bypass path
        p.scan(1'b1, 4, 68'h5, dout);
        chk(dout[3:0], 4'h1);
        p.scan(1'b0, 8, 68'h3C, dout);
        chk(dout[7:0], 8'h78);
        chk(p.bad, 0);
    endtask

    task automatic t_bsr();
        p.scan(1'b1, 4, 68'h1, dout);
        p.scan(1'b0, BSR, 68'h5A3C, dout);
        chk(dout[BSR-1:0], bsr_in);
        p.scan(1'b1, 4, 68'h0, dout);
        p.scan(1'b0, BSR, 68'h96E1, dout);
        chk({bsr_drive, bsr_out}, {1'b1, 16'h96E1});
    endtask

    // five mode-select highs from inside Shift-DR must drop the extest path
    task automatic t_tlr();
        p.scan(1'b1, 4, 68'h0, dout);
        p.step(1'b1, 1'b0, 1'b0);
        p.step(1'b0, 1'b1, 1'b0);
        p.step(1'b0, 1'b0, 1'b0);
        p.step(1'b1, 1'b1, 1'b1);
        repeat (4) p.step(1'b1, 1'b0, 1'b0);
        p.step(1'b0, 1'b1, 1'b0);
        p.scan(1'b0, 2, 68'h3, dout);
        chk({bsr_drive, dout[1:0]}, 3'h2);
        chk(p.bad, 0);
    endtask

    task automatic access(input logic [1:0] sz, input logic we,
            input logic ofs, input logic [31:0] a, input logic [31:0] ea,
            input logic er, input logic [31:0] rd, input logic pv,
            input logic [32:0] prev);
        logic [67:0] cmd;
        cmd = {a ^ 32'h0BAD_F00D, a, ofs, we, sz};
        p.scan(1'b0, 68, cmd, dout);
        if (pv)
            chk({dout[67:36], dout[1:0]}, {prev[31:0], 1'b0, prev[32]});
        for (int i = 0; i < 40 && dbg_req !== 1'b1; i++)
            @(posedge ref_clk);
        // slow core: the request must hold while unanswered
        repeat (3) @(posedge ref_clk);
        chk({dbg_req, dbg_size, dbg_we, dbg_addr, dbg_wdata},
            {1'b1, sz, we, ea, cmd[67:36]});
        dbg_ack   <= 1'b1;
        dbg_err   <= er;
        dbg_rdata <= rd;
        @(posedge ref_clk);
        dbg_ack   <= 1'b0;
        dbg_err   <= ~er;
        dbg_rdata <= ~rd;
        @(posedge ref_clk);
        #1;
        chk(dbg_req, 1'b0);
        @(posedge ref_clk);
    endtask

    task automatic t_debug();
        p.scan(1'b1, 4, 68'h8, dout);
        access(2'h2, 1'b0, 1'b0, 32'h1000_0000, 32'h1000_0000, 1'b1,
               32'hDEAD_BEEF, 1'b0, 33'h0);
        access(2'h1, 1'b1, 1'b1, 32'h0000_0010, 32'h1000_0010, 1'b0,
               32'h0000_5A5A, 1'b1, {1'b1, 32'hDEAD_BEEF});
        access(2'h0, 1'b0, 1'b1, 32'hF000_0000, 32'h0000_0000, 1'b0,
               32'h0000_00C3, 1'b1, {1'b0, 32'h0000_5A5A});
        // size code 3 is refused: no request, error flag raised
        p.scan(1'b0, 68, 68'h3, dout);
        chk({dout[67:36], dout[1:0]}, {32'h0000_00C3, 2'h0});
        for (int i = 0; i < 40; i++) begin
            @(posedge ref_clk);
            chk(dbg_req, 1'b0);
        end
        p.scan(1'b0, 68, 68'h3, dout);
        chk({dbg_req, dout[1:0]}, 3'h1);
        chk(p.bad, 0);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        reset = 1'b1;
        bsr_in = 16'hC3A5;
        dbg_ack = 1'b0;
        dbg_err = 1'b0;
        dbg_rdata = 32'h0;
        error_cnt = 0;
        n_checks = 0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({tdo, tdo_oe, bsr_drive, dbg_req}, 4'h0);
        t_bypass();
        t_bsr();
        t_tlr();
        t_debug();
        give_verdict();
    end

    // whole run needs about 210 us
    initial begin
        #2_000_000;
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
